// >>> bench/gp_ext_model.sv
module gp_ext_model (
   // Low drive from the device, one bit a pin
   input wire logic [17:0] drv_low_in,
   // Keys closed by the bench
   input wire logic [17:0] key_low_in,
   // Resulting pin levels
   output logic [17:0] level_out
);
   timeunit 1ns;
   timeprecision 1ns;
   assign level_out = ~(drv_low_in | key_low_in);
endmodule

// >>> bench/tb.sv
`include "gp_port_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import gp_pkg::*;
   typedef struct packed {gp_addr_t wa; gp_word_t wd; gp_addr_t ra; gp_word_t re;} gp_tb_row_t;
   logic clk_in = 0;
   logic sys_rst_in = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic t1 = 0;
   logic t2 = 0;
   logic bk = 0;
   logic pready, pslverr, t2ev, irq, wake;
   gp_addr_t paddr = '0;
   gp_word_t pwdata = '0;
   gp_word_t prdata, rd;
   logic err;
   logic [5:0] ind_o, ind_oe;
   logic [3:0] g0_o, g0_oe, g1_o, g1_oe;
   logic [1:0] g2_o, g2_oe, g3_o, g3_oe;
   logic [11:0] pu;
   logic [17:0] keys = '0;
   logic [17:0] lvl;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_irq = 0;
   int n_ev = 0;
   int base;
   gp_tb_row_t rows [8] = '{
      '{`GP_OFF_IND_LATCH, 32'h15, `GP_OFF_IND_LATCH, 32'h15},
      '{`GP_OFF_IND_LATCH, 32'h2A, `GP_OFF_IND_PIN, 32'h2A},
      '{`GP_OFF_GRP_LATCH, 32'hA5C, `GP_OFF_GRP_PIN, 32'hA5C},
      '{`GP_OFF_CK_PORT, 32'h1, `GP_OFF_IND_LATCH, 32'h26},
      '{`GP_OFF_CK_PORT, 32'h2, `GP_OFF_CK_PORT, 32'h2},
      '{`GP_OFF_PULLUP, 32'hFFFFFFFF, `GP_OFF_PULLUP, 32'h1F},
      '{`GP_OFF_WAKE, 32'hFFFFFFFF, `GP_OFF_WAKE, 32'h3F},
      '{`GP_OFF_IRQ_CTRL, 32'hFFFFFFF6, `GP_OFF_IRQ_CTRL, 32'h6}};
   gp_addr_t rst_a [5] = '{`GP_OFF_IND_LATCH, `GP_OFF_GRP_LATCH, `GP_OFF_PULLUP, `GP_OFF_WAKE, `GP_OFF_IRQ_CTRL};
   gp_word_t rst_v [5] = '{32'h3F, 32'hFFF, 32'h0, 32'h0, 32'h0};

   gp_port uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .individual_pins_in(lvl[5:0]), .individual_pins_out(ind_o), .individual_pins_oe_out(ind_oe),
      .group_zero_pins_in(lvl[9:6]), .group_zero_pins_out(g0_o), .group_zero_pins_oe_out(g0_oe),
      .group_one_pins_in(lvl[13:10]), .group_one_pins_out(g1_o), .group_one_pins_oe_out(g1_oe),
      .group_two_pins_in(lvl[15:14]), .group_two_pins_out(g2_o), .group_two_pins_oe_out(g2_oe),
      .group_three_pins_in(lvl[17:16]), .group_three_pins_out(g3_o), .group_three_pins_oe_out(g3_oe),
      .pullup_en_out(pu), .timer1_uflow_in(t1), .timer2_uflow_in(t2), .timer2_event_out(t2ev),
      .ext_irq_out(irq), .ram_backup_in(bk), .wake_req_out(wake));

   gp_ext_model ext (.drv_low_in({g3_oe & ~g3_o, g2_oe & ~g2_o, g1_oe & ~g1_o, g0_oe & ~g0_o, ind_oe & ~ind_o}),
      .key_low_in(keys), .level_out(lvl));

   initial begin
      forever #5 clk_in = ~clk_in;
   end

   task summarize;
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (irq === 1'b1) n_irq++;
      if (t2ev === 1'b1) n_ev++;
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end

   task chk(input gp_word_t got, input gp_word_t exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task idle(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Setup, access, hold until pready sampled high
   task apb(input logic w, input gp_addr_t a, input gp_word_t d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rdchk(input gp_addr_t a, input gp_word_t e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task rst;
      sys_rst_in <= 1'b1;
      idle(2);
      sys_rst_in <= 1'b0;
   endtask

   task key_pulse(input int k);
      keys[k] <= 1'b1;
      idle(4);
      keys[k] <= 1'b0;
      idle(6);
   endtask

   task uflow(input logic a, input logic b);
      @(posedge clk_in);
      t1 <= a;
      t2 <= b;
      @(posedge clk_in);
      t1 <= 1'b0;
      t2 <= 1'b0;
      idle(3);
   endtask

   initial begin
      rst();
      foreach (rows[i]) begin
         apb(1'b1, rows[i].wa, rows[i].wd);
         idle(4);
         rdchk(rows[i].ra, rows[i].re);
      end
      chk(32'(pu), 32'hFFF);
      rst();
      foreach (rst_a[i]) rdchk(rst_a[i], rst_v[i]);
      chk(32'({pu, ind_oe, g0_oe, g1_oe, g2_oe, g3_oe}), 32'h0);
      keys[0] <= 1'b1;
      idle(4);
      rdchk(`GP_OFF_IND_PIN, 32'h3E);
      keys <= '0;
      apb(1'b1, `GP_OFF_WAKE, 32'h1);
      bk <= 1'b1;
      keys[3] <= 1'b1;
      idle(5);
      chk(32'(wake), 32'h0);
      keys[2] <= 1'b1;
      idle(5);
      chk(32'(wake), 32'h1);
      keys <= '0;
      bk <= 1'b0;
      idle(2);
      base = n_irq;
      key_pulse(13);
      chk(n_irq - base, 0);
      apb(1'b1, `GP_OFF_IRQ_CTRL, 32'h8);
      key_pulse(13);
      chk(n_irq - base, 1);
      base = n_ev;
      key_pulse(12);
      chk(n_ev - base, 1);
      apb(1'b1, `GP_OFF_IRQ_CTRL, 32'h9);
      idle(2);
      chk(32'(g1_oe), 32'h0);
      uflow(1'b1, 1'b0);
      chk(32'(g1_oe), 32'h4);
      uflow(1'b0, 1'b1);
      chk(32'(g1_oe), 32'h4);
      rdchk(`GP_OFF_GRP_PIN, 32'hFBF);
      uflow(1'b1, 1'b0);
      chk(32'(g1_oe), 32'h0);
      apb(1'b1, `GP_OFF_IRQ_CTRL, 32'hB);
      uflow(1'b0, 1'b1);
      chk(32'(g1_oe), 32'h4);
      rdchk(5'h02, 32'h0);
      chk(32'(err), 32'h1);
      summarize();
   end
endmodule

// >>> hdl/gp_pkg.sv
package gp_pkg;
   typedef logic [31:0] gp_word_t;
   typedef logic [4:0] gp_addr_t;
   typedef enum logic [0:0] {
      GP_CNT_SRC_T1 = 1'b0,
      GP_CNT_SRC_T2 = 1'b1
   } gp_cnt_src_t;
endpackage

// >>> hdl/gp_port.sv
`include "gp_port_cfg.svh"
module gp_port (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire gp_pkg::gp_addr_t paddr_in,
   input wire gp_pkg::gp_word_t pwdata_in,
   output gp_pkg::gp_word_t prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Individual pins
   input wire logic [5:0] individual_pins_in,
   output logic [5:0] individual_pins_out,
   output logic [5:0] individual_pins_oe_out,
   // Group pins
   input wire logic [3:0] group_zero_pins_in,
   output logic [3:0] group_zero_pins_out,
   output logic [3:0] group_zero_pins_oe_out,
   input wire logic [3:0] group_one_pins_in,
   output logic [3:0] group_one_pins_out,
   output logic [3:0] group_one_pins_oe_out,
   input wire logic [1:0] group_two_pins_in,
   output logic [1:0] group_two_pins_out,
   output logic [1:0] group_two_pins_oe_out,
   input wire logic [1:0] group_three_pins_in,
   output logic [1:0] group_three_pins_out,
   output logic [1:0] group_three_pins_oe_out,
   // Pull-up controls: ind2, ind3, group0 x4, group1 x4, group2 x2
   output logic [11:0] pullup_en_out,
   // Timer and interrupt side
   input wire logic timer1_uflow_in,
   input wire logic timer2_uflow_in,
   output logic timer2_event_out,
   output logic ext_irq_out,
   // Back-up state
   input wire logic ram_backup_in,
   output logic wake_req_out
);
   import gp_pkg::*;

   localparam int NPIN = 18;

   logic [5:0] ind_latch;
   logic [11:0] grp_latch;
   logic [4:0] pullup_en;
   logic [5:0] wake_en;
   logic [3:0] irq_ctrl;
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   logic [NPIN-1:0] pin_prev;
   logic cnt_toggle;
   logic wr_en;
   logic access;
   logic [NPIN-1:0] next_oe;
   logic next_wake;
   gp_word_t next_rdata;
   logic next_err;

   function automatic gp_word_t gp_zext(input logic [11:0] v);
      gp_zext = {20'h00000, v};
   endfunction

   assign access = psel_in & penable_in;
   assign wr_en = access & pready_out & pwrite_in;

   // Pin synchroniser, first stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         // Idle-high reset, no false edge on release
         pin_meta <= '1;
         pin_sync <= '1;
         pin_prev <= '1;
      end else begin
         pin_meta <= {group_three_pins_in, group_two_pins_in, group_one_pins_in,
                      group_zero_pins_in, individual_pins_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ind_latch <= `GP_RST_IND_LATCH;
      end else if (wr_en && paddr_in == `GP_OFF_IND_LATCH) begin
         ind_latch <= pwdata_in[5:0];
      end else if (wr_en && paddr_in == `GP_OFF_CK_PORT) begin
         ind_latch[`GP_IND_C_BIT] <= pwdata_in[0];
         ind_latch[`GP_IND_K_BIT] <= pwdata_in[1];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         grp_latch <= `GP_RST_GRP_LATCH;
      end else if (wr_en && paddr_in == `GP_OFF_GRP_LATCH) begin
         grp_latch <= pwdata_in[11:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pullup_en <= `GP_RST_PULLUP;
         wake_en <= `GP_RST_WAKE;
      end else begin
         if (wr_en && paddr_in == `GP_OFF_PULLUP) begin
            pullup_en <= pwdata_in[4:0];
         end
         if (wr_en && paddr_in == `GP_OFF_WAKE) begin
            wake_en <= pwdata_in[5:0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         irq_ctrl <= `GP_RST_IRQ_CTRL;
      end else if (wr_en && paddr_in == `GP_OFF_IRQ_CTRL) begin
         irq_ctrl <= pwdata_in[3:0];
      end
   end

   always_comb begin
      next_oe = ~{grp_latch, ind_latch};
      if (irq_ctrl[`GP_CNT_OUT_EN_BIT] && !cnt_toggle) begin
         next_oe[`GP_G1_CNT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         individual_pins_oe_out <= '0;
         group_zero_pins_oe_out <= '0;
         group_one_pins_oe_out <= '0;
         group_two_pins_oe_out <= '0;
         group_three_pins_oe_out <= '0;
         individual_pins_out <= '0;
         group_zero_pins_out <= '0;
         group_one_pins_out <= '0;
         group_two_pins_out <= '0;
         group_three_pins_out <= '0;
         pullup_en_out <= '0;
      end else begin
         individual_pins_oe_out <= next_oe[5:0];
         group_zero_pins_oe_out <= next_oe[9:6];
         group_one_pins_oe_out <= next_oe[13:10];
         group_two_pins_oe_out <= next_oe[15:14];
         group_three_pins_oe_out <= next_oe[17:16];
         pullup_en_out <= {{2{pullup_en[4]}}, {4{pullup_en[3]}}, {4{pullup_en[2]}},
                           pullup_en[1], pullup_en[0]};
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cnt_toggle <= 1'b1;
      end else if (irq_ctrl[`GP_CNT_SEL_BIT] == GP_CNT_SRC_T2 ? timer2_uflow_in : timer1_uflow_in) begin
         cnt_toggle <= ~cnt_toggle;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         timer2_event_out <= 1'b0;
         ext_irq_out <= 1'b0;
      end else begin
         timer2_event_out <= pin_sync[`GP_G1_CNT_BIT] & ~pin_prev[`GP_G1_CNT_BIT];
         ext_irq_out <= irq_ctrl[`GP_IRQ_GATE_BIT] & pin_sync[`GP_G1_IRQ_BIT]
                        & ~pin_prev[`GP_G1_IRQ_BIT];
      end
   end

   // low level on enabled pin wakes, IRQ pin via its own enable only with IRQ gate open, via group one enable always
   always_comb begin
      next_wake = (wake_en[0] & ~pin_sync[`GP_IND_C_BIT])
                | (wake_en[1] & ~pin_sync[`GP_IND_K_BIT])
                | (wake_en[2] & ~&pin_sync[9:6])
                | (wake_en[3] & ~&pin_sync[13:10])
                | (wake_en[4] & ~&pin_sync[15:14])
                | (wake_en[`GP_WAKE_IRQ_BIT] & irq_ctrl[`GP_IRQ_GATE_BIT] & ~pin_sync[`GP_G1_IRQ_BIT]);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wake_req_out <= 1'b0;
      end else begin
         wake_req_out <= ram_backup_in & next_wake;
      end
   end

   always_comb begin
      next_err = 1'b0;
      unique case (paddr_in)
         `GP_OFF_IND_LATCH: next_rdata = gp_zext({6'h00, ind_latch});
         `GP_OFF_IND_PIN: next_rdata = gp_zext({6'h00, pin_sync[5:0]});
         `GP_OFF_GRP_LATCH: next_rdata = gp_zext(grp_latch);
         `GP_OFF_GRP_PIN: next_rdata = gp_zext(pin_sync[17:6]);
         `GP_OFF_PULLUP: next_rdata = gp_zext({7'h00, pullup_en});
         `GP_OFF_WAKE: next_rdata = gp_zext({6'h00, wake_en});
         `GP_OFF_IRQ_CTRL: next_rdata = gp_zext({8'h00, irq_ctrl});
         `GP_OFF_CK_PORT: next_rdata = gp_zext({10'h000, pin_sync[`GP_IND_K_BIT], pin_sync[`GP_IND_C_BIT]});
         default: begin
            next_rdata = '0;
            next_err = 1'b1;
         end
      endcase
   end

   // APB: one wait state per access
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= '0;
      end else begin
         pready_out <= access & ~pready_out;
         pslverr_out <= access & ~pready_out & next_err;
         prdata_out <= (access & ~pready_out & ~pwrite_in) ? next_rdata : '0;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_latch_release: assert property (wr_en && paddr_in == `GP_OFF_IND_LATCH && pwdata_in[0] ##1 1
      |=> !individual_pins_oe_out[0])
      else $error("latch one did not release pin");
   a_latch_drive: assert property (wr_en && paddr_in == `GP_OFF_GRP_LATCH && !pwdata_in[0]
      |=> ##1 group_zero_pins_oe_out[0])
      else $error("latch zero did not drive pin");
   a_od_low: assert property (individual_pins_out == 6'h00 && group_one_pins_out == 4'h0)
      else $error("open-drain pin driven high");
   a_alias_write: assert property (wr_en && paddr_in == `GP_OFF_CK_PORT
      |=> ind_latch[`GP_IND_K_BIT] == $past(pwdata_in[1]))
      else $error("one-bit port alias failed");
   a_irq_gated: assert property (!irq_ctrl[`GP_IRQ_GATE_BIT] ##1 !irq_ctrl[`GP_IRQ_GATE_BIT]
      |-> !ext_irq_out)
      else $error("interrupt passed closed gate");
   a_irq_edge: assert property (irq_ctrl[`GP_IRQ_GATE_BIT] && pin_sync[`GP_G1_IRQ_BIT]
      && !pin_prev[`GP_G1_IRQ_BIT] |=> ext_irq_out)
      else $error("interrupt edge lost");
   a_wake_now: assert property (ram_backup_in && wake_en[0] && !pin_sync[`GP_IND_C_BIT]
      |=> wake_req_out)
      else $error("enabled wakeup did not fire");
   a_wake_quiet: assert property (wake_en == 6'h00 |=> !wake_req_out)
      else $error("wakeup without enable");
   a_pin_read: assert property (pready_out && !pwrite_in && !pslverr_out
      && $past(paddr_in) == `GP_OFF_GRP_PIN |-> prdata_out[11:0] == $past(pin_sync[17:6]))
      else $error("pin read mismatch");
   a_cnt_toggle: assert property (irq_ctrl[`GP_CNT_SEL_BIT] && timer2_uflow_in
      |=> cnt_toggle != $past(cnt_toggle))
      else $error("count output did not toggle");
   a_apb_wait: assert property (access && !pready_out |=> pready_out)
      else $error("APB answer late");

   c_wake: cover property (ram_backup_in ##1 wake_req_out);
   c_irq: cover property (ext_irq_out);
   c_count_out: cover property (irq_ctrl[`GP_CNT_OUT_EN_BIT] ##1 group_one_pins_oe_out[2]);
   c_err: cover property (pslverr_out);
endmodule

// >>> hdl/gp_port_cfg.svh
`ifndef GP_PORT_CFG_SVH
`define GP_PORT_CFG_SVH

// Register byte offsets
`define GP_OFF_IND_LATCH 5'h00
`define GP_OFF_IND_PIN 5'h04
`define GP_OFF_GRP_LATCH 5'h08
`define GP_OFF_GRP_PIN 5'h0C
`define GP_OFF_PULLUP 5'h10
`define GP_OFF_WAKE 5'h14
`define GP_OFF_IRQ_CTRL 5'h18
`define GP_OFF_CK_PORT 5'h1C

// Field positions
`define GP_IRQ_GATE_BIT 3
`define GP_CNT_OUT_EN_BIT 0
`define GP_CNT_SEL_BIT 1
`define GP_WAKE_IRQ_BIT 5
`define GP_IND_C_BIT 2
`define GP_IND_K_BIT 3
// Count and interrupt pins as positions in the combined 18-bit pin vector
`define GP_G1_CNT_BIT 12
`define GP_G1_IRQ_BIT 13

// Reset values
`define GP_RST_IND_LATCH 6'h3F
`define GP_RST_GRP_LATCH 12'hFFF
`define GP_RST_PULLUP 5'h00
`define GP_RST_WAKE 6'h00
`define GP_RST_IRQ_CTRL 4'h0

`endif
